// *** design/imubfc_avg_stage.sv ***
// One moving-average stage of the cascaded averaging filter
`timescale 1ns/1ps
module imubfc_avg_stage (
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire logic [2:0]                  taps_log2,
    input  wire logic                        in_valid,
    input  wire logic [imubfc_pkg::DATA_W-1:0] in_data,
    output logic                             out_valid,
    output logic [imubfc_pkg::DATA_W-1:0]    out_data
);
    import imubfc_pkg::*;

    typedef struct packed {
        logic [HIST_DEPTH-1:0][DATA_W-1:0] hist;
        logic [PTR_W-1:0]                  ptr;
        logic signed [SUM_W-1:0]           sum;
        logic [2:0]                        b_prev;
        logic                              out_valid;
        logic [DATA_W-1:0]                 out_data;
    } imubfc_stage_s;

    imubfc_stage_s s_reg;
    imubfc_stage_s s_next;

    // ------------------------------------------------------------------
    // Tap count from filter size
    // ------------------------------------------------------------------
    function automatic logic [PTR_W:0] tap_count(input logic [2:0] b);
        tap_count = (PTR_W+1)'(1) << b;
    endfunction

    // ------------------------------------------------------------------
    // Running sum over the last 2^B samples
    // ------------------------------------------------------------------
    always_comb begin
        logic [PTR_W-1:0]         old_idx;
        logic [PTR_W:0]           taps;
        logic signed [SUM_W-1:0]  new_sum;
        logic signed [DATA_W-1:0] in_s;
        logic signed [DATA_W-1:0] old_s;
        old_idx = '0;
        taps    = tap_count(taps_log2);
        new_sum = '0;
        in_s    = signed'(in_data);
        old_s   = '0;
        s_next  = s_reg;
        s_next.out_valid = 1'b0;
        // Size change clears history, sample of that cycle still kept
        if (taps_log2 != s_reg.b_prev) begin
            s_next.hist   = '0;
            s_next.sum    = '0;
            s_next.ptr    = '0;
            s_next.b_prev = taps_log2;
        end
        if (in_valid) begin
            old_idx = s_next.ptr - taps[PTR_W-1:0];
            old_s   = signed'(s_next.hist[old_idx]);
            new_sum = s_next.sum + SUM_W'(in_s) - SUM_W'(old_s);
            s_next.hist[s_next.ptr] = in_data;
            s_next.ptr       = s_next.ptr + PTR_W'(1);
            s_next.sum       = new_sum;
            s_next.out_data  = DATA_W'(new_sum >>> taps_log2);
            s_next.out_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign out_valid = s_reg.out_valid;
    assign out_data  = s_reg.out_data;

endmodule

// *** design/imubfc_pkg.sv ***
// Constants and carrier types of the bias and filter register bank
package imubfc_pkg;

    // ------------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned SAMPLE_HZ    = 2000;
    localparam int unsigned SAMPLE_DIV   = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned DIV_W        = 13;
    localparam int unsigned FILT_UPD_US  = 30;
    localparam int unsigned FILT_UPD_CYC = (FILT_UPD_US * CLK_HZ) / 1_000_000;
    localparam int unsigned UPD_W        = 9;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned FR_WR_BIT   = 15;
    localparam int unsigned FR_ADDR_MSB = 14;
    localparam int unsigned FR_ADDR_LSB = 8;
    localparam int unsigned FR_DATA_MSB = 7;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_GZ_LO   = 7'h48;
    localparam logic [6:0] ADDR_GZ_HI   = 7'h4A;
    localparam logic [6:0] ADDR_AX_LO   = 7'h4C;
    localparam logic [6:0] ADDR_AX_HI   = 7'h4E;
    localparam logic [6:0] ADDR_AY_LO   = 7'h50;
    localparam logic [6:0] ADDR_AY_HI   = 7'h52;
    localparam logic [6:0] ADDR_AZ_LO   = 7'h54;
    localparam logic [6:0] ADDR_AZ_HI   = 7'h56;
    localparam logic [6:0] ADDR_FILT    = 7'h5C;
    localparam logic [6:0] ADDR_RANGE   = 7'h5E;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIAS_WORDS  = 8;
    localparam logic [15:0] BIAS_RST    = 16'h0000;
    localparam logic [2:0]  FILT_RST    = 3'h0;
    localparam logic [2:0]  FILT_B_MAX  = 3'h6;
    localparam int unsigned FILT_B_MSB  = 2;
    localparam int unsigned RANGE_LSB   = 2;
    localparam logic [1:0]  RANGE_RSVD  = 2'h3;
    localparam logic [1:0]  RANGE_RST   = 2'h0;

    // ------------------------------------------------------------------
    // Filter geometry
    // ------------------------------------------------------------------
    localparam int unsigned AXES        = 4;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned HIST_DEPTH  = 64;
    localparam int unsigned PTR_W       = 6;
    localparam int unsigned SUM_W       = 38;
    localparam int unsigned AX_GZ       = 0;
    localparam int unsigned AX_AX       = 1;
    localparam int unsigned AX_AY       = 2;
    localparam int unsigned AX_AZ       = 3;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } imubfc_spi_s;

    typedef struct packed {
        logic [AXES-1:0][DATA_W-1:0] axis;
    } imubfc_axes_s;

endpackage

// *** design/imubfc_top.sv ***
// Bias correction, averaging filter and register bank behind the serial port
`timescale 1ns/1ps
module imubfc_top #(
    parameter int unsigned SAMPLE_DIV_P = imubfc_pkg::SAMPLE_DIV
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire imubfc_pkg::imubfc_spi_s spi_in,
    output logic                         miso,
    output logic                         miso_oe,
    input  wire logic [1:0]              range_strap,
    input  wire imubfc_pkg::imubfc_axes_s raw_in,
    output imubfc_pkg::imubfc_axes_s     filt_out,
    output logic                         filt_valid,
    output logic                         sample_tick
);
    import imubfc_pkg::*;

    typedef struct packed {
        logic                              sclk_d;
        logic [FRAME_BITS-1:0]             rx;
        logic [CNT_W-1:0]                  cnt;
        logic [FRAME_BITS-1:0]             tx;
        logic [BIAS_WORDS-1:0][15:0]       bias;
        logic [2:0]                        filt_pend;
        logic [2:0]                        filt_act;
        logic [UPD_W-1:0]                  upd_cnt;
        logic                              upd_busy;
        logic [1:0]                        range;
        logic                              strap_done;
        logic [DIV_W-1:0]                  div;
        logic                              tick;
        logic [AXES-1:0][DATA_W-1:0]       corr;
    } imubfc_top_state_s;

    localparam imubfc_top_state_s TOP_RST = '{
        sclk_d:     1'b1,
        rx:         '0,
        cnt:        '0,
        tx:         '0,
        bias:       {BIAS_WORDS{BIAS_RST}},
        filt_pend:  FILT_RST,
        filt_act:   FILT_RST,
        upd_cnt:    '0,
        upd_busy:   1'b0,
        range:      RANGE_RST,
        strap_done: 1'b0,
        div:        '0,
        tick:       1'b0,
        corr:       '0
    };

    imubfc_top_state_s s_reg;
    imubfc_top_state_s s_next;

    // ------------------------------------------------------------------
    // Address decode, read mux and bias add helpers
    // ------------------------------------------------------------------
    function automatic logic bias_hit(input logic [6:0] a);
        bias_hit = (a >= ADDR_GZ_LO) && (a <= (ADDR_AZ_HI + 7'h01));
    endfunction

    function automatic logic [2:0] bias_idx(input logic [6:0] a);
        logic [6:0] d;
        d = a - ADDR_GZ_LO;
        bias_idx = d[3:1];
    endfunction

    function automatic logic [15:0] read_word(
        input imubfc_top_state_s st,
        input logic [6:0]        a
    );
        logic [6:0] al;
        al = {a[6:1], 1'b0};
        read_word = 16'h0000;
        if (bias_hit(al)) begin
            read_word = st.bias[bias_idx(al)];
        end else if (al == ADDR_FILT) begin
            read_word = {13'h0000, st.filt_act};
        end else if (al == ADDR_RANGE) begin
            read_word = {12'h000, st.range, RANGE_RSVD};
        end
    endfunction

    function automatic logic signed [DATA_W-1:0] add_bias(
        input logic [DATA_W-1:0] raw,
        input logic [15:0]       lo,
        input logic [15:0]       hi
    );
        add_bias = signed'(raw) + signed'({hi, lo});
    endfunction

    // ------------------------------------------------------------------
    // Serial port, register writes, sample divider
    // ------------------------------------------------------------------
    always_comb begin
        logic                  edge_r;
        logic                  edge_f;
        logic [FRAME_BITS-1:0] frame;
        logic [6:0]            addr;
        logic [7:0]            wdat;
        logic [2:0]            bi;
        edge_r = 1'b0;
        edge_f = 1'b0;
        frame  = '0;
        addr   = '0;
        wdat   = '0;
        bi     = '0;
        s_next = s_reg;
        s_next.sclk_d = spi_in.sclk;
        s_next.tick   = 1'b0;
        edge_r = !s_reg.sclk_d && spi_in.sclk && !spi_in.cs_n;
        edge_f = s_reg.sclk_d && !spi_in.sclk && !spi_in.cs_n;

        if (!s_reg.strap_done) begin
            s_next.range      = range_strap;
            s_next.strap_done = 1'b1;
        end

        if (s_reg.upd_busy) begin
            if (s_reg.upd_cnt <= UPD_W'(1)) begin
                s_next.filt_act = s_reg.filt_pend;
                s_next.upd_busy = 1'b0;
                s_next.upd_cnt  = '0;
            end else begin
                s_next.upd_cnt = s_reg.upd_cnt - UPD_W'(1);
            end
        end

        if (spi_in.cs_n) begin
            s_next.cnt = '0;
        end else if (edge_r) begin
            frame     = {s_reg.rx[FRAME_BITS-2:0], spi_in.mosi};
            s_next.rx = frame;
            s_next.cnt = s_reg.cnt + CNT_W'(1);
            if (s_reg.cnt == CNT_W'(FRAME_BITS - 1)) begin
                s_next.cnt = '0;
                addr = frame[FR_ADDR_MSB:FR_ADDR_LSB];
                wdat = frame[FR_DATA_MSB:0];
                if (frame[FR_WR_BIT]) begin
                    if (bias_hit(addr)) begin
                        bi = bias_idx(addr);
                        if (addr[0]) begin
                            s_next.bias[bi][15:8] = wdat;
                        end else begin
                            s_next.bias[bi][7:0] = wdat;
                        end
                    end else if (addr == ADDR_FILT) begin
                        if (wdat[FILT_B_MSB:0] > FILT_B_MAX) begin
                            s_next.filt_pend = FILT_B_MAX;
                        end else begin
                            s_next.filt_pend = wdat[FILT_B_MSB:0];
                        end
                        s_next.upd_busy = 1'b1;
                        s_next.upd_cnt  = UPD_W'(FILT_UPD_CYC);
                    end
                end else begin
                    s_next.tx = read_word(s_reg, addr);
                end
            end
        end else if (edge_f && (s_reg.cnt != '0)) begin
            s_next.tx = {s_reg.tx[FRAME_BITS-2:0], 1'b0};
        end

        if (s_reg.div >= DIV_W'(SAMPLE_DIV_P - 1)) begin
            s_next.div  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + DIV_W'(1);
        end

        if (s_reg.tick) begin
            s_next.corr[AX_GZ] = add_bias(raw_in.axis[AX_GZ],
                s_reg.bias[0], s_reg.bias[1]);
            s_next.corr[AX_AX] = add_bias(raw_in.axis[AX_AX],
                s_reg.bias[2], s_reg.bias[3]);
            s_next.corr[AX_AY] = add_bias(raw_in.axis[AX_AY],
                s_reg.bias[4], s_reg.bias[5]);
            s_next.corr[AX_AZ] = add_bias(raw_in.axis[AX_AZ],
                s_reg.bias[6], s_reg.bias[7]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_reg <= TOP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Two cascaded averaging stages per axis
    // ------------------------------------------------------------------
    logic                    corr_valid;
    logic [AXES-1:0]         st1_valid;
    logic [AXES-1:0][DATA_W-1:0] st1_data;
    logic [AXES-1:0]         st2_valid;
    logic [AXES-1:0][DATA_W-1:0] st2_data;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            corr_valid <= 1'b0;
        end else begin
            corr_valid <= s_reg.tick;
        end
    end

    for (genvar g = 0; g < AXES; g++) begin : g_axis
        imubfc_avg_stage u_st1 (
            .ref_clk   (ref_clk),
            .rstn      (rstn),
            .taps_log2 (s_reg.filt_act),
            .in_valid  (corr_valid),
            .in_data   (s_reg.corr[g]),
            .out_valid (st1_valid[g]),
            .out_data  (st1_data[g])
        );
        imubfc_avg_stage u_st2 (
            .ref_clk   (ref_clk),
            .rstn      (rstn),
            .taps_log2 (s_reg.filt_act),
            .in_valid  (st1_valid[g]),
            .in_data   (st1_data[g]),
            .out_valid (st2_valid[g]),
            .out_data  (st2_data[g])
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign filt_out.axis = st2_data;
    assign filt_valid    = st2_valid[AX_GZ];
    assign sample_tick   = s_reg.tick;
    assign miso          = s_reg.tx[FRAME_BITS-1];
    assign miso_oe       = !spi_in.cs_n;

endmodule

// *** dv/imubfc_assertions.sv ***
// Port assertions of the bias and filter register bank
`timescale 1ns/1ps
module imubfc_assertions #(
    parameter int unsigned SAMPLE_DIV_P = 20
) (
    input wire logic                     ref_clk,
    input wire logic                     rstn,
    input wire imubfc_pkg::imubfc_spi_s  spi_in,
    input wire logic                     miso,
    input wire logic                     miso_oe,
    input wire imubfc_pkg::imubfc_axes_s filt_out,
    input wire logic                     filt_valid,
    input wire logic                     sample_tick
);
    import imubfc_pkg::*;
    logic [15:0] gap_reg;
    logic        seen_reg;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------------
    // Tick spacing counter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn || sample_tick) begin
            gap_reg <= 16'h0001;
        end else begin
            gap_reg <= gap_reg + 16'h0001;
        end
        seen_reg <= rstn && (seen_reg || sample_tick);
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_tick_period: assert property (sample_tick && seen_reg
        |-> gap_reg == 16'(SAMPLE_DIV_P)) else $error("tick period");
    a_tick_pulse: assert property (sample_tick |=> !sample_tick)
        else $error("tick too long");
    a_valid_lat: assert property (sample_tick |-> ##3 filt_valid)
        else $error("valid late");
    a_valid_cause: assert property (filt_valid |-> $past(sample_tick, 3))
        else $error("valid without tick");
    a_valid_pulse: assert property (filt_valid |=> (!filt_valid)[*8])
        else $error("valid repeats");
    a_out_hold: assert property (!filt_valid |-> $stable(filt_out))
        else $error("output moved");
    a_oe_follow: assert property (miso_oe == !spi_in.cs_n)
        else $error("enable wrong");
    a_miso_hold: assert property (spi_in.cs_n && $past(spi_in.cs_n)
        |-> $stable(miso)) else $error("miso moved idle");

    c_valid: cover property (filt_valid);
    c_frame: cover property (!spi_in.cs_n && $rose(spi_in.sclk));
    c_tick: cover property (sample_tick ##20 sample_tick);
endmodule

bind imubfc_top imubfc_assertions #(.SAMPLE_DIV_P(SAMPLE_DIV_P)) i_chk (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .spi_in      (spi_in),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .filt_out    (filt_out),
    .filt_valid  (filt_valid),
    .sample_tick (sample_tick)
);

// *** dv/imubfc_host_model.sv ***
// Serial host model driving mode 3 frames
`timescale 1ns/1ps
module imubfc_host_model (
    input  wire logic                ref_clk,
    output imubfc_pkg::imubfc_spi_s  spi,
    input  wire logic                miso
);
    import imubfc_pkg::*;
    localparam int HALF = 3;

    initial begin
        spi = '{cs_n: 1'b1, sclk: 1'b1, mosi: 1'b0};
    end

    // One 16-bit frame, MSB first
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge ref_clk);
        #1 spi.cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (HALF) @(posedge ref_clk);
            #1 spi.sclk = 1'b0;
            spi.mosi = tx[i];
            repeat (HALF) @(posedge ref_clk);
            #1 rx[i] = miso;
            spi.sclk = 1'b1;
        end
        repeat (HALF + 2) @(posedge ref_clk);
        #1 spi.cs_n = 1'b1;
        spi.mosi = ~spi.mosi;
    endtask
endmodule

// *** dv/imubfc_top_tb_top.sv ***
// Testbench of the bias and filter register bank
`timescale 1ns/1ps
module imubfc_top_tb_top;
    import imubfc_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rstn = 1'b0;
    imubfc_spi_s  spi;
    logic         miso;
    logic         miso_oe;
    logic [1:0]   range_strap = 2'h2;
    imubfc_axes_s raw_in = '0;
    imubfc_axes_s filt_out;
    logic         filt_valid;
    logic         sample_tick;
    int           n_mismatch = 0;
    int           comparisons = 0;
    logic [15:0]  bw [8];

    always #50 ref_clk = ~ref_clk;

    imubfc_top #(.SAMPLE_DIV_P(20)) i_imubfc_top (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .spi_in      (spi),
        .miso        (miso),
        .miso_oe     (miso_oe),
        .range_strap (range_strap),
        .raw_in      (raw_in),
        .filt_out    (filt_out),
        .filt_valid  (filt_valid),
        .sample_tick (sample_tick)
    );

    imubfc_host_model i_imubfc_host_model (
        .ref_clk (ref_clk),
        .spi     (spi),
        .miso    (miso)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #1 rstn = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1 rstn = 1'b1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] rx;
        i_imubfc_host_model.xfer({1'b1, a, d[7:0]}, rx);
        i_imubfc_host_model.xfer({1'b1, a | 7'h01, d[15:8]}, rx);
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [15:0] rx;
        i_imubfc_host_model.xfer({1'b0, a, 8'h00}, rx);
        i_imubfc_host_model.xfer(16'h0000, d);
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (filt_valid !== 1'b1 && n < 100);
        if (filt_valid !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals();
        logic [15:0] d;
        for (int i = 0; i < 9; i++) begin
            rd(i < 8 ? ADDR_GZ_LO + 7'(2 * i) : ADDR_FILT, d);
            chk("reset", 32'h0, 32'(d));
        end
    endtask

    task automatic t_bias_rw();
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            bw[i] = 16'h9E37 * 16'(i + 1);
            wr(ADDR_GZ_LO + 7'(2 * i), bw[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_GZ_LO + 7'(2 * i), d);
            chk("bias", 32'(bw[i]), 32'(d));
        end
    endtask

    task automatic t_datapath();
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            raw_in.axis[i] = 32'h8000_0100 + 32'(i) * 32'h1357_9BDF;
        end
        wait_valid();
        wait_valid();
        for (int i = 0; i < 4; i++) begin
            e = raw_in.axis[i] + {bw[2 * i + 1], bw[2 * i]};
            chk("lane", e, filt_out.axis[i]);
        end
    endtask

    task automatic t_filter();
        logic [15:0] d;
        logic [31:0] g;
        logic [31:0] st [3] = '{32'h2, 32'h6, 32'h8};
        g = {bw[1], bw[0]};
        raw_in.axis[0] = 32'h0 - g;
        for (int k = 6; k > 0; k -= 5) begin
            wr(ADDR_FILT, 16'(k));
            repeat (310) @(posedge ref_clk);
            rd(ADDR_FILT, d);
            chk("filter size", 32'(k), 32'(d));
        end
        wait_valid();
        raw_in.axis[0] = 32'h8 - g;
        for (int k = 0; k < 3; k++) begin
            wait_valid();
            chk("step", st[k], filt_out.axis[0]);
        end
    endtask

    task automatic t_range();
        logic [15:0] d;
        for (int c = 0; c < 4; c++) begin
            range_strap = 2'(c);
            do_reset();
            wr(ADDR_RANGE, 16'hFFFF);
            rd(ADDR_RANGE, d);
            chk("range", {28'h0, 2'(c), 2'h3}, 32'(d));
        end
        rd(ADDR_GZ_LO, d);
        chk("bias after reset", 32'h0, 32'(d));
        rd(7'h40, d);
        chk("unmapped", 32'h0, 32'(d));
    endtask

    initial begin
        do_reset();
        t_reset_vals();
        t_bias_rw();
        t_datapath();
        t_filter();
        t_range();
        test_done();
    end
endmodule
